// ==== common/bmc_pkg.sv ====
// shared constants and types for the buck modulation mode controller
package bmc_pkg;

  // register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  // register offsets
  localparam logic [7:0] MODE_CTRL_OFS  = 8'h00;
  localparam logic [7:0] HW_CTRL0_OFS   = 8'h01;
  localparam logic [7:0] WAKE_STAT0_OFS = 8'h02;
  localparam logic [7:0] REG_STAT_OFS   = 8'h03;

  // mode command codes in mode_control_reg[1:0]
  localparam logic [1:0] CMD_NORMAL = 2'h0;
  localparam logic [1:0] CMD_STOP   = 2'h1;
  localparam logic [1:0] CMD_SLEEP  = 2'h2;

  // field positions
  localparam int CMD_LSB        = 0;
  localparam int HW_CFG_LSB     = 0;
  localparam int WS_UPSHIFT_BIT = 0;
  localparam int WS_WAKE_BIT    = 1;

  // chip operating modes
  typedef enum logic [2:0] {
    ST_NORMAL   = 3'h0,
    ST_STOP     = 3'h1,
    ST_SLEEP    = 3'h2,
    ST_FAILSAFE = 3'h3,
    ST_RESTART  = 3'h4
  } bmc_mode_t;

  // hardware_control_reg0 layout, bit 3 downward
  typedef struct packed {
    logic boost_en;
    logic lag_time_select;
    logic pin_controlled_modulation;
    logic auto_upshift_enable;
  } bmc_hwcfg_t;

  localparam logic [3:0] HW_CTRL0_RST = 4'h0;

  // synchronised pin inputs
  typedef struct packed {
    logic fail_safe;
    logic vs_below_boost_th;
    logic buck_above_rst_th;
    logic upshift_current;
    logic xcvr_wake;
    logic wake_input_pin;
  } bmc_pins_t;

  // lag timing
  localparam int CLK_FREQ_KHZ  = 20000;
  localparam int LAG_LONG_US   = 1000;
  localparam int LAG_SHORT_US  = 100;
  localparam int LAG_LONG_CYC  = LAG_LONG_US * CLK_FREQ_KHZ / 1000;
  localparam int LAG_SHORT_CYC = LAG_SHORT_US * CLK_FREQ_KHZ / 1000;
  typedef logic [14:0] bmc_lag_t;

endpackage

// ==== rtl/bmc_sync.sv ====
// two-flop synchroniser for asynchronous pin levels
module bmc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  // levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule

// ==== rtl/bmc_buck_mod_ctrl.sv ====
// buck modulation and regulator mode control with register port
//
// Behaviour
// - stop entry switches buck PWM to PFM, unless pin mode without auto has the pin high
// - default stop keeps PFM throughout
// - auto upshift beats pin control
// - both options clear: PFM throughout stop
// - overcurrent upshifts, flags and interrupts
// - only stop re-command restores PFM
// - arm auto detection after lag time
// - lag time on each stop command issued in PWM
// - lag select: 1 ms or 100 us
// - pin mode: pin level picks modulation
// - pin driven changes skip lag
// - stop to normal switches to PWM
// - boost untouched on stop to normal
// - sleep and fail-safe disable both regulators
// - wake in sleep, or in fail-safe once fail_safe is low, enters restart
// - restart enables buck, reset after threshold
// - restart re-enables boost per stored config
// - buck active normal, stop, restart
module bmc_buck_mod_ctrl #(
  parameter int unsigned LAG_LONG_CYC = bmc_pkg::LAG_LONG_CYC
) (
  // clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       rst_i,
  // register port
  input  wire logic [bmc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [bmc_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                       wr_en_i,
  input  wire logic                       rd_en_i,
  output logic      [bmc_pkg::DATA_W-1:0] rd_data_o,
  // asynchronous pin and comparator levels
  input  wire logic                       wake_input_pin_i,
  input  wire logic                       xcvr_wake_i,
  input  wire logic                       upshift_current_i,
  input  wire logic                       buck_above_rst_th_i,
  input  wire logic                       vs_below_boost_th_i,
  input  wire logic                       fail_safe_i,
  // regulator control and system outputs
  output logic                            buck_enable_o,
  output logic                            buck_pwm_o,
  output logic                            boost_run_o,
  output logic                            reset_out_n_o,
  output logic                            interrupt_out_n_o
);

  bmc_pkg::bmc_pins_t  pins_raw;
  bmc_pkg::bmc_pins_t  pins_s;
  bmc_pkg::bmc_hwcfg_t hw_q;
  bmc_pkg::bmc_mode_t  state_q;
  bmc_pkg::bmc_mode_t  state_d;
  bmc_pkg::bmc_lag_t   lag_cnt_q;

  logic                       auto_s_q;
  logic                       pin_s_q;
  logic                       upshifted_q;
  logic                       pwm_q;
  logic                       pwm_d;
  logic                       buck_en_q;
  logic                       boost_q;
  logic                       rst_n_q;
  logic                       int_n_q;
  logic                       ws_up_q;
  logic                       ws_wake_q;
  logic [bmc_pkg::DATA_W-1:0] rd_data_q;
  logic                       cmd_wr;
  logic [1:0]                 cmd;
  logic                       stop_entry;
  logic                       up_evt;
  logic                       lag_busy;
  logic                       wake;
  logic                       active_d;
  logic                       ws_wr;

  assign pins_raw = '{fail_safe:         fail_safe_i,
                      vs_below_boost_th: vs_below_boost_th_i,
                      buck_above_rst_th: buck_above_rst_th_i,
                      upshift_current:   upshift_current_i,
                      xcvr_wake:         xcvr_wake_i,
                      wake_input_pin:    wake_input_pin_i};

  bmc_sync #(
    .W ($bits(bmc_pkg::bmc_pins_t))
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .d_i       (pins_raw),
    .q_o       (pins_s)
  );

  assign cmd_wr   = wr_en_i && (addr_i == bmc_pkg::MODE_CTRL_OFS);
  assign cmd      = wr_data_i[bmc_pkg::CMD_LSB +: 2];
  assign ws_wr    = wr_en_i && (addr_i == bmc_pkg::WAKE_STAT0_OFS);
  assign wake     = pins_s.wake_input_pin | pins_s.xcvr_wake;
  assign lag_busy = (lag_cnt_q != '0);

  // mode sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      bmc_pkg::ST_NORMAL: begin
        if (cmd_wr && cmd == bmc_pkg::CMD_STOP) begin
          state_d = bmc_pkg::ST_STOP;
        end else if (cmd_wr && cmd == bmc_pkg::CMD_SLEEP) begin
          state_d = bmc_pkg::ST_SLEEP;
        end
      end
      bmc_pkg::ST_STOP: begin
        if (cmd_wr && cmd == bmc_pkg::CMD_NORMAL) begin
          state_d = bmc_pkg::ST_NORMAL;
        end else if (cmd_wr && cmd == bmc_pkg::CMD_SLEEP) begin
          state_d = bmc_pkg::ST_SLEEP;
        end
      end
      bmc_pkg::ST_SLEEP: begin
        if (wake) begin
          state_d = bmc_pkg::ST_RESTART;
        end
      end
      bmc_pkg::ST_FAILSAFE: begin
        if (wake && !pins_s.fail_safe) begin
          state_d = bmc_pkg::ST_RESTART;
        end
      end
      bmc_pkg::ST_RESTART: begin
        if (pins_s.buck_above_rst_th) begin
          state_d = bmc_pkg::ST_NORMAL;
        end
      end
      default: begin
        state_d = bmc_pkg::ST_RESTART;
      end
    endcase
    if (pins_s.fail_safe) begin
      state_d = bmc_pkg::ST_FAILSAFE;
    end
  end

  // a stop command from normal or stop, also the re-command after an upshift
  assign stop_entry = cmd_wr && (cmd == bmc_pkg::CMD_STOP) && (state_d == bmc_pkg::ST_STOP);

  assign active_d = (state_d != bmc_pkg::ST_SLEEP) && (state_d != bmc_pkg::ST_FAILSAFE);

  assign up_evt = (state_q == bmc_pkg::ST_STOP) && (state_d == bmc_pkg::ST_STOP) && !stop_entry
                  && auto_s_q && !lag_busy && !upshifted_q && pins_s.upshift_current;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= bmc_pkg::ST_RESTART;
    end else begin
      state_q <= state_d;
    end
  end

  // software configuration
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hw_q <= bmc_pkg::bmc_hwcfg_t'(bmc_pkg::HW_CTRL0_RST);
    end else if (wr_en_i && addr_i == bmc_pkg::HW_CTRL0_OFS) begin
      hw_q <= bmc_pkg::bmc_hwcfg_t'(wr_data_i[bmc_pkg::HW_CFG_LSB +: 4]);
    end
  end

  // options held for the whole stop period
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      auto_s_q <= 1'b0;
      pin_s_q  <= 1'b0;
    end else if (stop_entry) begin
      auto_s_q <= hw_q.auto_upshift_enable;
      pin_s_q  <= hw_q.pin_controlled_modulation;
    end
  end

  // lag timer starts on each stop command issued while in PWM
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lag_cnt_q <= '0;
    end else if (state_d != bmc_pkg::ST_STOP) begin
      lag_cnt_q <= '0;
    end else if (stop_entry && pwm_q) begin
      lag_cnt_q <= hw_q.lag_time_select ? bmc_pkg::bmc_lag_t'(LAG_LONG_CYC)
                                        : bmc_pkg::bmc_lag_t'(bmc_pkg::LAG_SHORT_CYC);
    end else if (lag_busy) begin
      lag_cnt_q <= lag_cnt_q - 15'h0001;
    end
  end

  // latched upshift, held until the next stop command or exit from stop
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      upshifted_q <= 1'b0;
    end else if (stop_entry || state_d != bmc_pkg::ST_STOP) begin
      upshifted_q <= 1'b0;
    end else if (up_evt) begin
      upshifted_q <= 1'b1;
    end
  end

  // modulation choice
  always_comb begin
    pwm_d = 1'b1;
    case (state_d)
      bmc_pkg::ST_STOP: begin
        if (stop_entry) begin
          pwm_d = hw_q.pin_controlled_modulation && !hw_q.auto_upshift_enable
                  && pins_s.wake_input_pin;
        end else if (auto_s_q) begin
          pwm_d = upshifted_q || up_evt;
        end else if (pin_s_q) begin
          pwm_d = pins_s.wake_input_pin;
        end else begin
          pwm_d = 1'b0;
        end
      end
      bmc_pkg::ST_SLEEP: pwm_d = 1'b0;
      bmc_pkg::ST_FAILSAFE: pwm_d = 1'b0;
      bmc_pkg::ST_NORMAL: pwm_d = 1'b1;
      bmc_pkg::ST_RESTART: pwm_d = 1'b1;
      default: pwm_d = 1'b1;
    endcase
  end

  // regulator enables and reset pin
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pwm_q     <= 1'b1;
      buck_en_q <= 1'b1;
      boost_q   <= 1'b0;
      rst_n_q   <= 1'b0;
    end else begin
      pwm_q     <= pwm_d;
      buck_en_q <= active_d;
      boost_q   <= active_d && hw_q.boost_en && pins_s.vs_below_boost_th;
      rst_n_q   <= active_d && (state_d != bmc_pkg::ST_RESTART);
    end
  end

  // wake status; hardware set wins over a write-one clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ws_up_q   <= 1'b0;
      ws_wake_q <= 1'b0;
      int_n_q   <= 1'b1;
    end else begin
      ws_up_q   <= up_evt || (ws_up_q && !(ws_wr && wr_data_i[bmc_pkg::WS_UPSHIFT_BIT]));
      ws_wake_q <= (state_d == bmc_pkg::ST_RESTART && !active_q())
                   || (ws_wake_q && !(ws_wr && wr_data_i[bmc_pkg::WS_WAKE_BIT]));
      int_n_q   <= !(up_evt || ws_up_q);
    end
  end

  function automatic logic active_q();
    active_q = (state_q != bmc_pkg::ST_SLEEP) && (state_q != bmc_pkg::ST_FAILSAFE);
  endfunction

  // read port, data in the cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_data_q <= '0;
    end else if (rd_en_i) begin
      case (addr_i)
        bmc_pkg::MODE_CTRL_OFS:  rd_data_q <= {13'h0000, state_q};
        bmc_pkg::HW_CTRL0_OFS:   rd_data_q <= {12'h000, hw_q};
        bmc_pkg::WAKE_STAT0_OFS: rd_data_q <= {14'h0000, ws_wake_q, ws_up_q};
        bmc_pkg::REG_STAT_OFS:   rd_data_q <= {11'h000, rst_n_q, boost_q, buck_en_q,
                                               lag_busy, pwm_q};
        default:                 rd_data_q <= '0;
      endcase
    end else begin
      rd_data_q <= '0;
    end
  end

  assign rd_data_o         = rd_data_q;
  assign buck_enable_o     = buck_en_q;
  assign buck_pwm_o        = pwm_q;
  assign boost_run_o       = boost_q;
  assign reset_out_n_o     = rst_n_q;
  assign interrupt_out_n_o = int_n_q;

  a_stop_entry_pfm: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (stop_entry && !hw_q.pin_controlled_modulation) |=> !pwm_q)
    else $error("stop entry did not select PFM");

  a_default_pfm_stop: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_q == bmc_pkg::ST_STOP && !auto_s_q && !pin_s_q) |-> !pwm_q)
    else $error("PWM in stop with both options clear");

  a_auto_priority: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_q == bmc_pkg::ST_STOP && auto_s_q && !upshifted_q) |-> !pwm_q)
    else $error("PWM in auto mode without an upshift");

  a_upshift_flag_int: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    up_evt |=> (pwm_q && ws_up_q && !int_n_q))
    else $error("upshift lacks PWM, flag or interrupt");

  a_lag_gate_arm: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_q == bmc_pkg::ST_STOP && auto_s_q && $rose(pwm_q)) |-> !$past(lag_busy))
    else $error("upshift armed during lag time");

  a_lag_inserted: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (stop_entry && pwm_q) |=> (lag_busy || state_q != bmc_pkg::ST_STOP) [*8])
    else $error("lag time not inserted on PWM to PFM");

  a_pin_follows: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_q == bmc_pkg::ST_STOP && $past(state_q) == bmc_pkg::ST_STOP && pin_s_q && !auto_s_q)
    |-> (pwm_q == $past(pins_s.wake_input_pin)))
    else $error("modulation does not follow the wake pin");

  a_normal_pwm: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    ($past(state_q) == bmc_pkg::ST_STOP && state_q == bmc_pkg::ST_NORMAL) |-> pwm_q)
    else $error("stop to normal left buck in PFM");

  a_sleep_regs_off: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_q == bmc_pkg::ST_SLEEP || state_q == bmc_pkg::ST_FAILSAFE) |-> (!buck_en_q && !boost_q))
    else $error("regulator enabled in sleep or fail-safe");

  a_reset_release: assert property (
    @(posedge sys_clk_i) disable iff (rst_i)
    $rose(rst_n_q) |-> ($past(pins_s.buck_above_rst_th) && buck_en_q))
    else $error("reset released before buck threshold");

endmodule

// ==== sim/bmc_plant.sv ====
// analog plant model: buck output ramp and load current
module bmc_plant #(
  parameter int RAMP = 6
) (
  // clock
  input  wire logic clk_i,
  // regulator control from the device, load level from the bench
  input  wire logic buck_enable_i,
  input  wire logic load_high_i,
  // comparator levels back to the device
  output logic      buck_above_rst_th_o,
  output logic      upshift_current_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  // output crosses the reset level only after a ramp, falls on the next clock edge when off
  always @(posedge clk_i) begin
    if (!buck_enable_i) begin
      cnt <= 0;
    end else if (cnt < RAMP) begin
      cnt <= cnt + 1;
    end
  end
  assign buck_above_rst_th_o = (cnt == RAMP);
  // load current only exists while the buck supplies it
  assign upshift_current_o = load_high_i & buck_enable_i;
endmodule

// ==== sim/tb_bmc_buck_mod_ctrl.sv ====
// self-checking bench for the buck modulation mode controller
`define CHK(nm, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
  end \
end
module tb_bmc_buck_mod_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LAG = 40;
  localparam int SLAG = bmc_pkg::LAG_SHORT_CYC;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdat = 16'h0000;
  logic        wr   = 1'b0;
  logic        rd   = 1'b0;
  logic        pin  = 1'b0;
  logic        xw   = 1'b0;
  logic        load = 1'b0;
  logic        vsb  = 1'b0;
  logic        fs   = 1'b0;
  logic [15:0] seed = 16'hfbd9;
  logic [15:0] rdat;
  logic [15:0] rv;
  logic        up;
  logic        above;
  logic        buck_en;
  logic        pwm;
  logic        bst;
  logic        reset_out_n;
  logic        irqn;
  int          num_errors = 0;
  int          n_tests    = 0;

  always #25 clk = ~clk;

  bmc_buck_mod_ctrl #(.LAG_LONG_CYC(LAG)) u_bmc_buck_mod_ctrl (
    .sys_clk_i(clk), .rst_i(rst), .addr_i(addr), .wr_data_i(wdat), .wr_en_i(wr),
    .rd_en_i(rd), .rd_data_o(rdat), .wake_input_pin_i(pin), .xcvr_wake_i(xw),
    .upshift_current_i(up), .buck_above_rst_th_i(above), .vs_below_boost_th_i(vsb),
    .fail_safe_i(fs), .buck_enable_o(buck_en), .buck_pwm_o(pwm), .boost_run_o(bst),
    .reset_out_n_o(reset_out_n), .interrupt_out_n_o(irqn));

  bmc_plant #(.RAMP(6)) u_bmc_plant (
    .clk_i(clk), .buck_enable_i(buck_en), .load_high_i(load),
    .buck_above_rst_th_o(above), .upshift_current_o(up));

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // expected stop-mode modulation from the options sampled at stop entry
  function automatic logic exp_pwm(input logic au, input logic pm, input logic p,
                                   input logic upd);
    return au ? upd : (pm ? p : 1'b0);
  endfunction

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdat <= d;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask

  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdat;
  endtask

  task automatic wait_reset_out_n;
    for (int i = 0; i < 100 && reset_out_n !== 1'b1; i++) @(posedge clk);
    #1;
    `CHK("reset_out_n", 1'b1, reset_out_n)
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    repeat (8 * SLAG + 20 * LAG + 3200) @(posedge clk);
    num_errors++;
    end_of_test();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wait_reset_out_n();
    wreg(8'h07, 16'hffff);
    rreg(bmc_pkg::HW_CTRL0_OFS);
    `CHK("hw_ctrl0 reset", 4'h0, rv[3:0])
    rreg(8'h07);
    `CHK("unmapped read", 16'h0000, rv)
    wreg(bmc_pkg::MODE_CTRL_OFS, 16'h0003);
    rreg(bmc_pkg::MODE_CTRL_OFS);
    `CHK("illegal cmd ignored", bmc_pkg::ST_NORMAL, rv[2:0])
    rreg(bmc_pkg::REG_STAT_OFS);
    `CHK("status normal", 16'h0015, rv)
    cyc(1);
    `CHK("read data cleared", 16'h0000, rdat)
    `CHK("buck on normal", 1'b1, buck_en)
    done("reset");
    @(posedge clk);
    load <= 1'b1;
    pin <= 1'b1;
    wreg(bmc_pkg::MODE_CTRL_OFS, {14'h0, bmc_pkg::CMD_STOP});
    cyc(1);
    `CHK("pwm stop entry", 1'b0, pwm)
    rreg(bmc_pkg::REG_STAT_OFS);
    `CHK("lag busy", 1'b1, rv[1])
    cyc(SLAG + 100);
    `CHK("pwm default stop", exp_pwm(1'b0, 1'b0, 1'b1, 1'b1), pwm)
    `CHK("no interrupt", 1'b1, irqn)
    done("default stop");
    wreg(bmc_pkg::MODE_CTRL_OFS, {14'h0, bmc_pkg::CMD_NORMAL});
    cyc(2);
    `CHK("pwm normal", 1'b1, pwm)
    // auto and pin both on, long lag; host enables before stop
    wreg(bmc_pkg::HW_CTRL0_OFS, 16'h0007);
    @(posedge clk);
    pin <= 1'b0;
    wreg(bmc_pkg::MODE_CTRL_OFS, {14'h0, bmc_pkg::CMD_STOP});
    cyc(LAG - 8);
    `CHK("pwm during lag", 1'b0, pwm)
    cyc(20);
    `CHK("pwm upshift", exp_pwm(1'b1, 1'b1, 1'b0, 1'b1), pwm)
    `CHK("interrupt low", 1'b0, irqn)
    rreg(bmc_pkg::WAKE_STAT0_OFS);
    `CHK("upshift flag", 1'b1, rv[0])
    @(posedge clk);
    load <= 1'b0;
    cyc(5);
    `CHK("pwm held", 1'b1, pwm)
    wreg(bmc_pkg::MODE_CTRL_OFS, {14'h0, bmc_pkg::CMD_STOP});
    wreg(bmc_pkg::WAKE_STAT0_OFS, 16'h0001);
    cyc(2);
    `CHK("pwm back to pfm", 1'b0, pwm)
    `CHK("interrupt cleared", 1'b1, irqn)
    done("auto upshift");
    wreg(bmc_pkg::MODE_CTRL_OFS, {14'h0, bmc_pkg::CMD_NORMAL});
    wreg(bmc_pkg::HW_CTRL0_OFS, 16'h0001);
    @(posedge clk);
    load <= 1'b1;
    wreg(bmc_pkg::MODE_CTRL_OFS, {14'h0, bmc_pkg::CMD_STOP});
    cyc(SLAG - 10);
    `CHK("short lag pfm", 1'b0, pwm)
    cyc(20);
    `CHK("short lag upshift", 1'b1, pwm)
    @(posedge clk);
    load <= 1'b0;
    wreg(bmc_pkg::MODE_CTRL_OFS, {14'h0, bmc_pkg::CMD_STOP});
    wreg(bmc_pkg::WAKE_STAT0_OFS, 16'h0001);
    done("short lag");
    wreg(bmc_pkg::HW_CTRL0_OFS, 16'h0002);
    wreg(bmc_pkg::MODE_CTRL_OFS, {14'h0, bmc_pkg::CMD_STOP});
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      @(posedge clk);
      pin <= seed[0];
      cyc(4);
      `CHK("pwm follows pin", exp_pwm(1'b0, 1'b1, seed[0], 1'b0), pwm)
    end
    // options change without a stop command must not take effect
    wreg(bmc_pkg::HW_CTRL0_OFS, 16'h0000);
    @(posedge clk);
    pin <= ~pin;
    cyc(4);
    `CHK("options held", pin, pwm)
    done("pin control");
    wreg(bmc_pkg::MODE_CTRL_OFS, {14'h0, bmc_pkg::CMD_NORMAL});
    wreg(bmc_pkg::HW_CTRL0_OFS, 16'h0008);
    @(posedge clk);
    vsb <= 1'b1;
    pin <= 1'b0;
    wreg(bmc_pkg::MODE_CTRL_OFS, {14'h0, bmc_pkg::CMD_STOP});
    wreg(bmc_pkg::MODE_CTRL_OFS, {14'h0, bmc_pkg::CMD_NORMAL});
    cyc(1);
    `CHK("boost kept", 1'b1, bst)
    done("boost");
    wreg(bmc_pkg::MODE_CTRL_OFS, {14'h0, bmc_pkg::CMD_SLEEP});
    cyc(2);
    `CHK("sleep buck off", 1'b0, buck_en)
    `CHK("sleep boost off", 1'b0, bst)
    wreg(bmc_pkg::MODE_CTRL_OFS, {14'h0, bmc_pkg::CMD_NORMAL});
    rreg(bmc_pkg::MODE_CTRL_OFS);
    `CHK("sleep refuses cmd", bmc_pkg::ST_SLEEP, rv[2:0])
    @(posedge clk);
    pin <= 1'b1;
    cyc(5);
    pin <= 1'b0;
    `CHK("restart buck on", 1'b1, buck_en)
    `CHK("reset held", 1'b0, reset_out_n)
    wait_reset_out_n();
    rreg(bmc_pkg::MODE_CTRL_OFS);
    `CHK("normal after wake", bmc_pkg::ST_NORMAL, rv[2:0])
    `CHK("boost restored", 1'b1, bst)
    rreg(bmc_pkg::WAKE_STAT0_OFS);
    `CHK("wake flag", 2'b10, rv[1:0])
    wreg(bmc_pkg::WAKE_STAT0_OFS, 16'h0002);
    done("sleep wake");
    @(posedge clk);
    fs <= 1'b1;
    cyc(5);
    `CHK("failsafe buck off", 1'b0, buck_en)
    `CHK("failsafe boost off", 1'b0, bst)
    @(posedge clk);
    fs <= 1'b0;
    xw <= 1'b1;
    cyc(5);
    xw <= 1'b0;
    wait_reset_out_n();
    rreg(bmc_pkg::MODE_CTRL_OFS);
    `CHK("normal after xcvr", bmc_pkg::ST_NORMAL, rv[2:0])
    `CHK("boost after xcvr", 1'b1, bst)
    done("fail-safe wake");
    end_of_test();
  end
endmodule
